// >>> ircodec_pkg.sv
// Shared constants and types for the infrared pulse codec
package ircodec_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam logic [3:0]  EVENT_CTRL_OFS  = 4'hC;
  localparam logic [3:0]  TX_PULSE_OFS    = 4'hD;
  localparam logic [3:0]  RX_FILTER_OFS   = 4'hE;
  localparam logic [3:0]  STATUS_OFS      = 4'hF;
  localparam int          EVENT_EN_BIT    = 0;
  localparam int          RX_FILTER_W     = 7;
  localparam logic [7:0]  READ_ZERO       = 8'h00;

  // ----------------------------------------------------------------
  // Pulse coding
  // ----------------------------------------------------------------
  localparam logic [7:0]  TX_PULSE_LENGTH_3_16       = 8'h00;
  localparam logic [7:0]  TX_PULSE_LENGTH_PASS       = 8'hFF;
  localparam int          PULSE_NUM       = 3;
  localparam int          PULSE_DEN_SHIFT = 4;
  localparam int          PERIOD_W        = 16;
  localparam int          RUN_W           = 8;
  localparam logic [7:0]  RUN_MAX         = 8'h80;

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  localparam int          TX_FIFO_WIDTH   = 1;
  localparam int          TX_FIFO_DEPTH   = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_PASS  = 3'h1,
    MODE_316   = 3'h2,
    MODE_FIXED = 3'h4
  } mode_t;

  typedef struct packed {
    logic                   event_input_enable;
    logic [7:0]             tx_pulse_length;
    logic [RX_FILTER_W-1:0] rx_pulse_filter;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{1'b0, 8'h00, 7'h00};

  typedef struct packed {
    logic [4:0] zero;
    logic       tx_queued;
    logic       rx_level;
    logic       tx_line;
  } status_t;

endpackage

// >>> ircodec_fifo.sv
// Small valid/ready FIFO with registered flags
module ircodec_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  // Fill side
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  // Drain side
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             push;
  logic             pop;

  assign push       = i_in_valid && o_in_ready;
  assign pop        = o_out_valid && i_out_ready;
  assign o_out_data = mem_r[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + CNT_W'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - CNT_W'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      count_r     <= '0;
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + PTR_W'(1);
      end
      count_r     <= count_nxt;
      o_in_ready  <= (count_nxt != CNT_W'(DEPTH));
      o_out_valid <= (count_nxt != '0);
    end
  end

endmodule // ircodec_fifo

// >>> infrared_pulse_codec.sv
// Infrared pulse encoder and receive filter between a USART and its pins
//
// Functional notes
// R01 - Event enable selects event channel as receive input
// R02 - Event input selected: receive pin ignored
// R03 - Transmit pulse length acts only in infrared mode
// R04 - Length zero: pulse is 3/16 bit period
// R05 - Length 1..254: pulse lasts that many clocks
// R06 - Pulse starts on baud clock rising edge
// R07 - Length 255: receive and transmit pass unchanged
// R08 - Software sets transmit length before enabling transmitter
// R09 - Receive filter acts only in infrared mode
// R10 - Filter value zero: no receive filtering
// R11 - Filter value x: accept after x+1 equal samples
// R12 - Software sets filter before enabling receiver
// R13 - Differing sample restarts the equal-sample count
module infrared_pulse_codec (
  // Clock and reset
  input  wire logic                       i_clock,
  input  wire logic                       i_reset_n,
  // Register port
  input  wire logic [ircodec_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [ircodec_pkg::DATA_W-1:0] i_wr_data,
  input  wire logic                       i_wr_en,
  input  wire logic                       i_rd_en,
  output logic [ircodec_pkg::DATA_W-1:0]  o_rd_data,
  // USART side
  input  wire logic                       i_infrared_comm_mode,
  input  wire logic                       i_transmitter_enable,
  input  wire logic                       i_baud_tick,
  input  wire logic                       i_tx_bit,
  input  wire logic                       i_tx_valid,
  output logic                            o_tx_ready,
  output logic                            o_usart_rxd,
  // Line side
  output logic                            o_ir_tx,
  input  wire logic                       i_rx_pin,
  input  wire logic                       i_event_rx
);
  import ircodec_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cfg_t                cfg_r;
  status_t             status;
  mode_t               tx_mode;
  mode_t               rx_mode;
  logic                fifo_bit;
  logic                fifo_valid;
  logic                fifo_pop;
  logic                cur_bit_r;
  logic [PERIOD_W-1:0] per_cnt_r;
  logic [PERIOD_W-1:0] period_r;
  logic [PERIOD_W+1:0] product;
  logic [PERIOD_W-1:0] width_316;
  logic [PERIOD_W-1:0] width;
  logic [PERIOD_W-1:0] pulse_cnt_r;
  logic [PERIOD_W-1:0] pulse_w_r;
  logic [PERIOD_W-1:0] hi_len_r;
  logic                start_pulse;
  logic                src;
  logic                prev_r;
  logic [RUN_W-1:0]    run_r;
  logic [RUN_W-1:0]    run_nxt;
  logic                filt_r;
  logic                filt_nxt;

  // Mode decode shared by both directions
  function automatic mode_t decode_mode(input logic infrared_comm_mode, input logic [7:0] len);
    if (!infrared_comm_mode || len == TX_PULSE_LENGTH_PASS) begin
      return MODE_PASS;
    end else if (len == TX_PULSE_LENGTH_3_16) begin
      return MODE_316;
    end
    return MODE_FIXED;
  endfunction

  assign tx_mode = decode_mode(i_infrared_comm_mode, cfg_r.tx_pulse_length); // R03
  assign rx_mode = decode_mode(i_infrared_comm_mode, cfg_r.tx_pulse_length); // R09

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  assign status = '{5'h00, fifo_valid, filt_r, o_ir_tx};

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_r <= CFG_RESET;
    end else if (i_wr_en) begin
      case (i_addr)
        EVENT_CTRL_OFS: begin
          cfg_r.event_input_enable <= i_wr_data[EVENT_EN_BIT];
        end
        TX_PULSE_OFS: begin
          cfg_r.tx_pulse_length <= i_wr_data;
        end
        RX_FILTER_OFS: begin
          cfg_r.rx_pulse_filter <= i_wr_data[RX_FILTER_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= READ_ZERO;
    end else if (i_rd_en) begin
      case (i_addr)
        EVENT_CTRL_OFS: o_rd_data <= {7'h00, cfg_r.event_input_enable};
        TX_PULSE_OFS:   o_rd_data <= cfg_r.tx_pulse_length;
        RX_FILTER_OFS:  o_rd_data <= {1'b0, cfg_r.rx_pulse_filter};
        STATUS_OFS:     o_rd_data <= status;
        default:        o_rd_data <= READ_ZERO;
      endcase
    end else begin
      o_rd_data <= READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  assign fifo_pop = i_baud_tick && i_transmitter_enable;

  ircodec_fifo #(
    .WIDTH (TX_FIFO_WIDTH),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_in_data   (i_tx_bit),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (o_tx_ready),
    .o_out_data  (fifo_bit),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop)
  );

  // Bit level held for one baud period; idle line is high
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_bit_r <= 1'b1;
    end else if (i_baud_tick) begin
      cur_bit_r <= !(fifo_pop && fifo_valid) || fifo_bit;
    end
  end

  // ----------------------------------------------------------------
  // Baud period measurement
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      per_cnt_r <= '0;
      period_r  <= '0;
    end else if (i_baud_tick) begin
      per_cnt_r <= '0;
      period_r  <= per_cnt_r + PERIOD_W'(1);
    end else if (per_cnt_r != '1) begin
      per_cnt_r <= per_cnt_r + PERIOD_W'(1);
    end
  end

  assign product   = period_r * (PERIOD_W+2)'(PULSE_NUM);
  assign width_316 = (product[PERIOD_W+1:PULSE_DEN_SHIFT] == '0) ? PERIOD_W'(1) :
                     PERIOD_W'(product >> PULSE_DEN_SHIFT); // R04
  assign width     = (tx_mode == MODE_316) ? width_316 :
                     PERIOD_W'(cfg_r.tx_pulse_length); // R05

  // ----------------------------------------------------------------
  // Pulse encoder
  // ----------------------------------------------------------------
  assign start_pulse = i_baud_tick && fifo_pop && fifo_valid && !fifo_bit; // R06

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pulse_cnt_r <= '0;
      pulse_w_r   <= '0;
      o_ir_tx     <= 1'b0;
    end else if (tx_mode == MODE_PASS) begin
      pulse_cnt_r <= '0;
      o_ir_tx     <= cur_bit_r; // R07
    end else if (start_pulse) begin
      pulse_cnt_r <= width;
      pulse_w_r   <= width;
      o_ir_tx     <= 1'b1; // R06
    end else if (pulse_cnt_r > PERIOD_W'(1)) begin
      pulse_cnt_r <= pulse_cnt_r - PERIOD_W'(1);
    end else begin
      pulse_cnt_r <= '0;
      o_ir_tx     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receive source and filter
  // ----------------------------------------------------------------
  assign src = cfg_r.event_input_enable ? i_event_rx : i_rx_pin; // R01 R02

  always_comb begin
    run_nxt  = RUN_W'(1); // R13
    filt_nxt = filt_r;
    if (src == prev_r) begin
      run_nxt = (run_r == RUN_MAX) ? RUN_MAX : run_r + RUN_W'(1);
    end
    if (cfg_r.rx_pulse_filter == '0) begin
      filt_nxt = src; // R10
    end else if (run_nxt >= RUN_W'(cfg_r.rx_pulse_filter) + RUN_W'(1)) begin
      filt_nxt = src; // R11
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_r <= 1'b0;
      run_r  <= '0;
      filt_r <= 1'b0;
    end else begin
      prev_r <= src;
      run_r  <= run_nxt;
      filt_r <= filt_nxt;
    end
  end

  // Pulse on the line marks a zero bit for the USART
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_usart_rxd <= 1'b1;
    end else if (rx_mode == MODE_PASS) begin
      o_usart_rxd <= src; // R07 R09
    end else begin
      o_usart_rxd <= !filt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hi_len_r <= '0;
    end else begin
      hi_len_r <= o_ir_tx ? hi_len_r + PERIOD_W'(1) : '0;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_tick_zero;
    start_pulse && tx_mode != MODE_PASS;
  endsequence

  sequence s_line_up;
    o_ir_tx ##1 o_ir_tx || pulse_w_r == PERIOD_W'(1);
  endsequence

  property p_event_source;
    cfg_r.event_input_enable && rx_mode != MODE_PASS && cfg_r.rx_pulse_filter == '0
      |=> o_usart_rxd == !$past(i_event_rx);
  endproperty
  a_event_source: assert property (p_event_source) else $error("event input not used"); // R01

  property p_pin_ignored;
    cfg_r.event_input_enable && rx_mode == MODE_PASS |=> o_usart_rxd == $past(i_event_rx);
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("receive pin not ignored"); // R02

  property p_tx_plain;
    !i_infrared_comm_mode |=> o_ir_tx == $past(cur_bit_r);
  endproperty
  a_tx_plain: assert property (p_tx_plain) else $error("pulse coding outside infrared mode"); // R03

  property p_width_316;
    $fell(o_ir_tx) && tx_mode == MODE_316 && $past(tx_mode) == MODE_316 && !$past(start_pulse)
      |-> hi_len_r == pulse_w_r && pulse_w_r != '0;
  endproperty
  a_width_316: assert property (p_width_316) else $error("3/16 pulse width wrong"); // R04

  property p_width_fixed;
    $fell(o_ir_tx) && tx_mode == MODE_FIXED && $stable(cfg_r.tx_pulse_length) && !$past(start_pulse)
      |-> hi_len_r == PERIOD_W'(cfg_r.tx_pulse_length);
  endproperty
  a_width_fixed: assert property (p_width_fixed) else $error("fixed pulse width wrong"); // R05

  property p_start_edge;
    s_tick_zero |=> s_line_up;
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("pulse not started at baud edge"); // R06

  property p_rise_cause;
    $rose(o_ir_tx) && tx_mode != MODE_PASS && $past(tx_mode) != MODE_PASS |-> $past(start_pulse);
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("pulse without baud edge"); // R06

  property p_pass_both;
    i_infrared_comm_mode && cfg_r.tx_pulse_length == TX_PULSE_LENGTH_PASS
      |=> o_usart_rxd == $past(src) && o_ir_tx == $past(cur_bit_r);
  endproperty
  a_pass_both: assert property (p_pass_both) else $error("pass-through altered signals"); // R07

  property p_rx_plain;
    !i_infrared_comm_mode |=> o_usart_rxd == $past(src);
  endproperty
  a_rx_plain: assert property (p_rx_plain) else $error("filter outside infrared mode"); // R09

  property p_no_filter;
    rx_mode != MODE_PASS && cfg_r.rx_pulse_filter == '0 |=> o_usart_rxd == !$past(src);
  endproperty
  a_no_filter: assert property (p_no_filter) else $error("unfiltered path delayed"); // R10

  property p_three_samples;
    cfg_r.rx_pulse_filter == 7'h02 && $stable(cfg_r.rx_pulse_filter) && $changed(filt_r)
      |-> $past(src, 1) == $past(src, 2) && $past(src, 2) == $past(src, 3);
  endproperty
  a_three_samples: assert property (p_three_samples) else $error("filter accepted short run"); // R11

  property p_restart;
    src != prev_r ##1 src == prev_r |-> run_r == RUN_W'(1);
  endproperty
  a_restart: assert property (p_restart) else $error("run count not restarted"); // R13

  // ----------------------------------------------------------------
  // Pulse loading checks
  // ----------------------------------------------------------------
  property p_empty_tick;
    i_baud_tick && !fifo_valid && tx_mode != MODE_PASS && !o_ir_tx |=> !o_ir_tx;
  endproperty
  a_empty_tick: assert property (p_empty_tick) else $error("pulse sent from empty queue"); // R06

  property p_fixed_load;
    start_pulse && tx_mode == MODE_FIXED |=> pulse_w_r == PERIOD_W'($past(cfg_r.tx_pulse_length));
  endproperty
  a_fixed_load: assert property (p_fixed_load) else $error("fixed pulse length not loaded"); // R05

  property p_width_min;
    start_pulse && tx_mode == MODE_316 |=> pulse_w_r != '0 && o_ir_tx;
  endproperty
  a_width_min: assert property (p_width_min) else $error("3/16 pulse of zero width"); // R04

endmodule // infrared_pulse_codec

// >>> ir_transceiver_model.sv
// Behavioural infrared transceiver facing the codec line pins
module ir_transceiver_model (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  // Codec line side
  input  wire logic i_ir_tx,
  input  wire logic i_baud_tick,
  input  wire logic i_idle_level,
  output logic      o_rx_pin,
  output logic      o_event_rx,
  // Measurements of the transmit line
  output int        o_high_width,
  output int        o_low_width,
  output int        o_lag,
  output int        o_falls,
  output int        o_rises
);
  timeunit 1ns;
  timeprecision 1ps;

  logic burst_r    = 1'b0;
  logic to_event_r = 1'b0;
  logic prev_r;
  int   high_run;
  int   low_run;
  int   since_tick;

  // ----------------------------------------------------------------
  // Receive lines: idle level, except the line chosen by to_event_r, which is inverse during a burst
  // ----------------------------------------------------------------
  assign o_rx_pin   = (burst_r && !to_event_r) ? !i_idle_level : i_idle_level;
  assign o_event_rx = (burst_r && to_event_r) ? !i_idle_level : i_idle_level;

  task automatic send_pulse(input int len, input logic to_event);
    int k;
    @(posedge i_clock);
    to_event_r <= to_event;
    burst_r    <= 1'b1;
    for (k = 0; k < len; k++) begin
      @(posedge i_clock);
    end
    burst_r <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Transmit line: run lengths and start delay after the baud tick
  // ----------------------------------------------------------------
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_r       <= 1'b0;
      high_run     <= 0;
      low_run      <= 0;
      since_tick   <= 0;
      o_high_width <= 0;
      o_low_width  <= 0;
      o_lag        <= 0;
      o_falls      <= 0;
      o_rises      <= 0;
    end else begin
      prev_r     <= i_ir_tx;
      since_tick <= i_baud_tick ? 1 : since_tick + 1;
      high_run   <= i_ir_tx ? high_run + 1 : 0;
      low_run    <= i_ir_tx ? 0 : low_run + 1;
      if (i_ir_tx && !prev_r) begin
        o_lag       <= since_tick;
        o_low_width <= low_run;
        o_rises     <= o_rises + 1;
      end
      if (!i_ir_tx && prev_r) begin
        o_high_width <= high_run;
        o_falls      <= o_falls + 1;
      end
    end
  end
endmodule // ir_transceiver_model

// >>> infrared_pulse_codec_tb_top.sv
// Self-checking bench for the infrared pulse codec
module infrared_pulse_codec_tb_top;
  import ircodec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock, reset_n, wr_en, rd_en, ir_mode, tx_enable;
  logic       baud_tick, tx_bit, tx_valid, tx_ready, usart_rxd, ir_tx;
  logic       rx_pin, event_rx, idle_level;
  logic [3:0] addr;
  logic [7:0] wr_data, rd_data;
  int         m_high, m_low, m_lag, m_falls, m_rises;
  int         tick_per, tick_cnt, low_cnt, fail_count, total_checks, i, nf;
  int         per_t[5] = '{300, 300, 300, 32, 300};
  logic [7:0] len_t[5] = '{8'h01, 8'h03, 8'hFE, 8'h00, 8'h00};
  int         exp_t[5] = '{1, 3, 254, 6, 56};

  infrared_pulse_codec dut (
    .i_clock(clock), .i_reset_n(reset_n), .i_addr(addr), .i_wr_data(wr_data), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .o_rd_data(rd_data), .i_infrared_comm_mode(ir_mode), .i_transmitter_enable(tx_enable),
    .i_baud_tick(baud_tick), .i_tx_bit(tx_bit), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_usart_rxd(usart_rxd), .o_ir_tx(ir_tx), .i_rx_pin(rx_pin), .i_event_rx(event_rx));

  ir_transceiver_model u_model (
    .i_clock(clock), .i_reset_n(reset_n), .i_ir_tx(ir_tx), .i_baud_tick(baud_tick),
    .i_idle_level(idle_level), .o_rx_pin(rx_pin), .o_event_rx(event_rx), .o_high_width(m_high),
    .o_low_width(m_low), .o_lag(m_lag), .o_falls(m_falls), .o_rises(m_rises));

  // ----------------------------------------------------------------
  // Clock, baud ticks and receive-line low counter
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    baud_tick <= (tick_cnt >= tick_per - 1);
    tick_cnt  <= (tick_cnt >= tick_per - 1) ? 0 : tick_cnt + 1;
    if (usart_rxd === 1'b0) low_cnt <= low_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------------
  task automatic cmp_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h got %h", nm, exp, got);
    end
  endtask

  task automatic cmp_count(input string nm, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("Error %s expected %0d got %0d", nm, exp, got);
    end
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en   <= 1'b0;
  endtask

  task automatic reg_check(input string nm, input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 cmp_byte(nm, exp, rd_data & mask);
  endtask

  task automatic push_bit(input logic b);
    int n;
    n = 0;
    @(posedge clock);
    tx_bit   <= b;
    tx_valid <= 1'b1;
    #1;
    while (tx_ready !== 1'b1 && n < 2000) begin
      @(posedge clock);
      #1 n++;
    end
    @(posedge clock);
    tx_valid <= 1'b0;
    tx_bit   <= 1'b1;
  endtask

  task automatic wait_edges(ref int cnt, input int target);
    int n;
    n = 0;
    while (cnt < target && n < 2000) begin
      @(posedge clock);
      n++;
    end
  endtask

  task automatic rx_try(input string nm, input logic [7:0] filt, input int l1, input int l2, input logic ev, input int exp);
    reg_write(RX_FILTER_OFS, filt);
    wait_cycles(12);
    #1 low_cnt = 0;
    u_model.send_pulse(l1, ev);
    if (l2 > 0) u_model.send_pulse(l2, ev);
    wait_cycles(20);
    cmp_count(nm, exp, low_cnt);
  endtask

  task automatic tx_pass(input string nm);
    tx_enable <= 1'b1;
    wait_cycles(80);
    nf = m_rises;
    push_bit(1'b0);
    wait_edges(m_rises, nf + 1);
    cmp_count(nm, tick_per, m_low);
  endtask

  task automatic final_report();
    $display("Totals: %0d checks, %0d mismatches", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {wr_en, rd_en, tx_valid, fail_count, total_checks, tick_cnt, low_cnt} = '0;
    {reset_n, addr, wr_data, idle_level} = '0;
    {ir_mode, tx_enable, tx_bit} = 3'b111;
    tick_per = 32;
    wait_cycles(2);
    #1 cmp_byte("reset outputs", 8'h01, {5'h00, tx_ready, ir_tx, usart_rxd});
    reset_n <= 1'b1;
    wait_cycles(2);
    reg_check("event ctrl reset", EVENT_CTRL_OFS, 8'hFF, 8'h00);
    reg_check("tx length reset", TX_PULSE_OFS, 8'hFF, 8'h00);
    reg_check("rx filter reset", RX_FILTER_OFS, 8'hFF, 8'h00);
    reg_write(4'h3, 8'hFF);
    reg_check("unmapped", 4'h3, 8'hFF, 8'h00);
    reg_write(EVENT_CTRL_OFS, 8'hFF);
    reg_check("event ctrl rw", EVENT_CTRL_OFS, 8'hFF, 8'h01);
    reg_write(RX_FILTER_OFS, 8'hFF);
    reg_check("rx filter rw", RX_FILTER_OFS, 8'hFF, 8'h7F);
    reg_write(TX_PULSE_OFS, 8'hA5);
    reg_check("tx length rw", TX_PULSE_OFS, 8'hFF, 8'hA5);
    reg_write(EVENT_CTRL_OFS, 8'h00);
    $display("Test registers done");
    for (i = 0; i < 5; i++) begin
      tick_per  = per_t[i];
      tx_enable <= 1'b0;
      reg_write(TX_PULSE_OFS, len_t[i]);
      tx_enable <= 1'b1;
      wait_cycles(2 * tick_per + 5);
      nf = m_falls;
      push_bit(1'b0);
      wait_edges(m_falls, nf + 1);
      cmp_count("pulse width", exp_t[i], m_high);
      cmp_count("pulse start", 1, m_lag);
    end
    $display("Test pulse widths done");
    tick_per  = 32;
    tx_enable <= 1'b0;
    reg_write(TX_PULSE_OFS, 8'h02);
    wait_cycles(80);
    repeat (4) push_bit(1'b0);
    wait_cycles(2);
    #1 cmp_byte("tx ready full", 8'h00, {7'h00, tx_ready});
    reg_check("status full", STATUS_OFS, 8'h05, 8'h04);
    nf = m_falls;
    tx_enable <= 1'b1;
    wait_edges(m_falls, nf + 4);
    cmp_count("drained pulses", 4, m_falls - nf);
    cmp_count("drained width", 2, m_high);
    reg_check("status empty", STATUS_OFS, 8'h04, 8'h00);
    $display("Test queue done");
    tx_enable <= 1'b0;
    reg_write(TX_PULSE_OFS, 8'hFF);
    tx_pass("pass tx low");
    ir_mode <= 1'b0;
    tx_enable <= 1'b0;
    reg_write(TX_PULSE_OFS, 8'h03);
    tx_pass("non infrared tx low");
    ir_mode <= 1'b1;
    reg_write(TX_PULSE_OFS, 8'h00);
    $display("Test pass transmit done");
    rx_try("short pulse", 8'h02, 2, 0, 1'b0, 0);
    rx_try("long pulse", 8'h02, 3, 0, 1'b0, 3);
    rx_try("broken run", 8'h02, 2, 2, 1'b0, 0);
    rx_try("no filter", 8'h00, 1, 0, 1'b0, 1);
    reg_write(EVENT_CTRL_OFS, 8'h01);
    rx_try("event raw", 8'h00, 1, 0, 1'b1, 1);
    rx_try("event pulse", 8'h02, 3, 0, 1'b1, 3);
    rx_try("pin ignored", 8'h02, 5, 0, 1'b0, 0);
    reg_write(EVENT_CTRL_OFS, 8'h00);
    idle_level <= 1'b1;
    reg_write(TX_PULSE_OFS, 8'hFF);
    rx_try("pass rx", 8'h02, 1, 0, 1'b0, 1);
    ir_mode <= 1'b0;
    reg_write(TX_PULSE_OFS, 8'h00);
    rx_try("non infrared rx", 8'h02, 1, 0, 1'b0, 1);
    $display("Test receive done");
    final_report();
  end

  initial begin
    #300000;
    fail_count++;
    $display("Error watchdog expected done got timeout");
    final_report();
  end
endmodule // infrared_pulse_codec_tb_top
